// File: verilog/blk_ctrl_defs.svh
// Purpose: offsets, field positions and reset values of the block controls
// Assumes: 8-bit register index, 16-bit register data
// Notes: included by bare name
`ifndef BLK_CTRL_DEFS_SVH
`define BLK_CTRL_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SOFT_RESET_OFS 8'h00
`define CLOCK_GATING_OFS 8'h01

// ****************************************
// Reset values and writable masks
// ****************************************
`define SOFT_RESET_RST 16'h0000
`define CLOCK_GATING_RST 16'h0000
`define SOFT_RESET_WMASK 16'h09FF
`define CLOCK_GATING_WMASK 16'h097F

// ****************************************
// Soft reset fields
// ****************************************
`define SR_FUSE_BIT 0
`define SR_LOSS_A_BIT 1
`define SR_LOSS_B_BIT 2
`define SR_LOSS_C_BIT 3
`define SR_ACT_A_BIT 4
`define SR_ACT_B_BIT 5
`define SR_LOOP_BIT 6
`define SR_TIME_BIT 7
`define SR_BIAS_BIT 8

// ****************************************
// Clock gating fields
// ****************************************
`define CG_FUSE_BIT 0
`define CG_LOSS_A_BIT 1
`define CG_LOSS_B_BIT 2
`define CG_LOSS_C_BIT 3
`define CG_ACT_A_BIT 4
`define CG_ACT_B_BIT 5
`define CG_GLOBAL_BIT 11

`endif

// File: verilog/blk_ctrl_pkg.sv
// Purpose: types shared by the block reset and clock gating logic
// Assumes: nothing beyond the defs header
// Notes: constants live in blk_ctrl_defs.svh
package blk_ctrl_pkg;
    typedef logic [7:0] reg_addr_t;
    typedef logic [15:0] reg_word_t;

    typedef struct packed {
        reg_word_t soft_reset;
        reg_word_t clock_gating;
        reg_word_t rdata;
        logic ack;
    } regs_s;

    typedef struct packed {
        logic [8:0] resets;
        logic [5:0] gates;
        logic global_gate;
    } outs_s;
endpackage

// File: verilog/ctrl_link_if.sv
// Purpose: carries the stored control words to the output stage
// Assumes: single clock domain
// Notes: src is the register file, dst the output stage
`timescale 1ns/1ps
interface ctrl_link_if;
    logic [15:0] soft_reset;
    logic [15:0] clock_gating;
    modport src (output soft_reset, output clock_gating);
    modport dst (input soft_reset, input clock_gating);
endinterface

// File: verilog/gate_outputs.sv
// Purpose: registers the reset holds and clock stops for each logic block
// Assumes: controls come from the register file over ctrl_link_if
// Notes: outputs lag the stored register by one clock
`timescale 1ns/1ps
`include "blk_ctrl_defs.svh"
module gate_outputs (
    input wire logic mclk,
    input wire logic rst_b,
    ctrl_link_if.dst link,
    output logic bias_calibration_soft_reset,
    output logic time_converter_soft_reset,
    output logic digital_loop_soft_reset,
    output logic activity_monitor_b_soft_reset,
    output logic activity_monitor_a_soft_reset,
    output logic signal_loss_monitor_c_soft_reset,
    output logic signal_loss_monitor_b_soft_reset,
    output logic signal_loss_monitor_a_soft_reset,
    output logic fuse_memory_soft_reset,
    output logic activity_monitor_b_gate,
    output logic activity_monitor_a_gate,
    output logic signal_loss_monitor_c_gate,
    output logic signal_loss_monitor_b_gate,
    output logic signal_loss_monitor_a_gate,
    output logic fuse_interface_gate,
    output logic global_digital_gate
);
    import blk_ctrl_pkg::*;

    outs_s out_r;
    outs_s out_nxt;

    // ****************************************
    // Output stage
    // ****************************************
    always_comb begin
        out_nxt = out_r;
        out_nxt.resets = link.soft_reset[`SR_BIAS_BIT:`SR_FUSE_BIT];
        out_nxt.gates = link.clock_gating[`CG_ACT_B_BIT:`CG_FUSE_BIT];
        out_nxt.global_gate = link.clock_gating[`CG_GLOBAL_BIT];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign bias_calibration_soft_reset = out_r.resets[`SR_BIAS_BIT];
    assign time_converter_soft_reset = out_r.resets[`SR_TIME_BIT];
    assign digital_loop_soft_reset = out_r.resets[`SR_LOOP_BIT];
    assign activity_monitor_b_soft_reset = out_r.resets[`SR_ACT_B_BIT];
    assign activity_monitor_a_soft_reset = out_r.resets[`SR_ACT_A_BIT];
    assign signal_loss_monitor_c_soft_reset = out_r.resets[`SR_LOSS_C_BIT];
    assign signal_loss_monitor_b_soft_reset = out_r.resets[`SR_LOSS_B_BIT];
    assign signal_loss_monitor_a_soft_reset = out_r.resets[`SR_LOSS_A_BIT];
    assign fuse_memory_soft_reset = out_r.resets[`SR_FUSE_BIT];
    assign activity_monitor_b_gate = out_r.gates[`CG_ACT_B_BIT];
    assign activity_monitor_a_gate = out_r.gates[`CG_ACT_A_BIT];
    assign signal_loss_monitor_c_gate = out_r.gates[`CG_LOSS_C_BIT];
    assign signal_loss_monitor_b_gate = out_r.gates[`CG_LOSS_B_BIT];
    assign signal_loss_monitor_a_gate = out_r.gates[`CG_LOSS_A_BIT];
    assign fuse_interface_gate = out_r.gates[`CG_FUSE_BIT];
    assign global_digital_gate = out_r.global_gate;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence held_one(logic s);
        s ##1 s;
    endsequence

    AST_BIAS_HOLD: assert property (held_one(link.soft_reset[`SR_BIAS_BIT]) |-> bias_calibration_soft_reset)
        else $error("bias reset not held");
    AST_TIME_FOLLOW: assert property (##1 time_converter_soft_reset == $past(link.soft_reset[`SR_TIME_BIT]))
        else $error("time converter reset wrong");
    AST_LOOP_RELEASE: assert property ($fell(link.soft_reset[`SR_LOOP_BIT]) |=> !digital_loop_soft_reset)
        else $error("loop reset not released");
    AST_MON_RESETS: assert property (##1 {activity_monitor_b_soft_reset, activity_monitor_a_soft_reset,
        signal_loss_monitor_c_soft_reset, signal_loss_monitor_b_soft_reset, signal_loss_monitor_a_soft_reset}
        == $past(link.soft_reset[`SR_ACT_B_BIT:`SR_LOSS_A_BIT]))
        else $error("monitor resets wrong");
    AST_FUSE_RESET: assert property (link.soft_reset[`SR_FUSE_BIT] |=> fuse_memory_soft_reset)
        else $error("fuse reset not held");
    AST_MON_GATES: assert property (##1 {activity_monitor_b_gate, activity_monitor_a_gate, signal_loss_monitor_c_gate,
        signal_loss_monitor_b_gate, signal_loss_monitor_a_gate}
        == $past(link.clock_gating[`CG_ACT_B_BIT:`CG_LOSS_A_BIT]))
        else $error("monitor gates wrong");
    AST_FUSE_GATE: assert property (!link.clock_gating[`CG_FUSE_BIT] |=> !fuse_interface_gate)
        else $error("fuse gate stuck");
    AST_GLOBAL_GATE: assert property (link.clock_gating[`CG_GLOBAL_BIT] |=> global_digital_gate [*2])
        else $error("global gate not held");
endmodule

// File: verilog/block_reset_clock_ctrl.sv
// Purpose: soft reset and clock gating control registers with their outputs
// Assumes: register accesses arrive decoded from the serial port, on mclk
// Notes: once the global digital gate is set, only rst_b recovers the block
//
// How it works
// - Bit 8 holds bias calibration in reset
// - Bit 7 holds time converter in reset
// - Bit 6 holds digital loop in reset
// - Bit 5 holds activity monitor b reset
// - Bit 4 holds activity monitor a reset
// - Bit 3 holds signal loss monitor c reset
// - Bit 2 holds signal loss monitor b reset
// - Bit 1 holds signal loss monitor a reset
// - Bit 0 holds fuse memory in reset
// - Set gate bits 5..0 and 11 stop their clocks; bits 6 and 8 are stored without effect
// - Gate bit 11 stops all other digital clocks
// - Global gate freezes register port until power cycle
// - Gate bits 5..1 stop the five monitors
// - Gate bit 0 stops fuse interface clock
`timescale 1ns/1ps
`include "blk_ctrl_defs.svh"
module block_reset_clock_ctrl (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire blk_ctrl_pkg::reg_addr_t reg_addr,
    input wire blk_ctrl_pkg::reg_word_t reg_wdata,
    output blk_ctrl_pkg::reg_word_t reg_rdata,
    output logic reg_ack,
    output logic bus_frozen,
    output logic bias_calibration_soft_reset,
    output logic time_converter_soft_reset,
    output logic digital_loop_soft_reset,
    output logic activity_monitor_b_soft_reset,
    output logic activity_monitor_a_soft_reset,
    output logic signal_loss_monitor_c_soft_reset,
    output logic signal_loss_monitor_b_soft_reset,
    output logic signal_loss_monitor_a_soft_reset,
    output logic fuse_memory_soft_reset,
    output logic activity_monitor_b_gate,
    output logic activity_monitor_a_gate,
    output logic signal_loss_monitor_c_gate,
    output logic signal_loss_monitor_b_gate,
    output logic signal_loss_monitor_a_gate,
    output logic fuse_interface_gate,
    output logic global_digital_gate
);
    import blk_ctrl_pkg::*;

    regs_s regs_r;
    regs_s regs_nxt;
    logic frozen;

    // ****************************************
    // Helpers
    // ****************************************
    // Unmapped index reads zero
    function automatic reg_word_t read_word(input reg_addr_t a, input regs_s r);
        reg_word_t v;
        v = '0;
        if (a == `SOFT_RESET_OFS) begin
            v = r.soft_reset;
        end else if (a == `CLOCK_GATING_OFS) begin
            v = r.clock_gating;
        end
        return v;
    endfunction

    // Read-only bits never take a written one
    function automatic reg_word_t masked(input reg_word_t w, input reg_word_t m);
        return w & m;
    endfunction

    // Register bus clock is stopped by the global gate, so nothing more gets in
    assign frozen = regs_r.clock_gating[`CG_GLOBAL_BIT];

    // ****************************************
    // Register file
    // ****************************************
    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.ack = 1'b0;
        if (!frozen) begin
            if (reg_wr_en) begin
                regs_nxt.ack = 1'b1;
                if (reg_addr == `SOFT_RESET_OFS) begin
                    regs_nxt.soft_reset = masked(reg_wdata, `SOFT_RESET_WMASK);
                end else if (reg_addr == `CLOCK_GATING_OFS) begin
                    regs_nxt.clock_gating = masked(reg_wdata, `CLOCK_GATING_WMASK);
                end
            end else if (reg_rd_en) begin
                regs_nxt.ack = 1'b1;
                regs_nxt.rdata = read_word(reg_addr, regs_r);
            end
        end
    end

    // Power cycle is the only way out of a frozen port
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            regs_r.soft_reset <= `SOFT_RESET_RST;
            regs_r.clock_gating <= `CLOCK_GATING_RST;
            regs_r.rdata <= 16'h0000;
            regs_r.ack <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign reg_rdata = regs_r.rdata;
    assign reg_ack = regs_r.ack;
    assign bus_frozen = regs_r.clock_gating[`CG_GLOBAL_BIT];

    // ****************************************
    // Output stage
    // ****************************************
    ctrl_link_if link ();

    assign link.soft_reset = regs_r.soft_reset;
    assign link.clock_gating = regs_r.clock_gating;

    gate_outputs u_gate_outputs (
        .mclk(mclk),
        .rst_b(rst_b),
        .link(link),
        .bias_calibration_soft_reset(bias_calibration_soft_reset),
        .time_converter_soft_reset(time_converter_soft_reset),
        .digital_loop_soft_reset(digital_loop_soft_reset),
        .activity_monitor_b_soft_reset(activity_monitor_b_soft_reset),
        .activity_monitor_a_soft_reset(activity_monitor_a_soft_reset),
        .signal_loss_monitor_c_soft_reset(signal_loss_monitor_c_soft_reset),
        .signal_loss_monitor_b_soft_reset(signal_loss_monitor_b_soft_reset),
        .signal_loss_monitor_a_soft_reset(signal_loss_monitor_a_soft_reset),
        .fuse_memory_soft_reset(fuse_memory_soft_reset),
        .activity_monitor_b_gate(activity_monitor_b_gate),
        .activity_monitor_a_gate(activity_monitor_a_gate),
        .signal_loss_monitor_c_gate(signal_loss_monitor_c_gate),
        .signal_loss_monitor_b_gate(signal_loss_monitor_b_gate),
        .signal_loss_monitor_a_gate(signal_loss_monitor_a_gate),
        .fuse_interface_gate(fuse_interface_gate),
        .global_digital_gate(global_digital_gate)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence sr_write;
        !frozen && reg_wr_en && reg_addr == `SOFT_RESET_OFS;
    endsequence

    sequence cg_write;
        !frozen && reg_wr_en && reg_addr == `CLOCK_GATING_OFS;
    endsequence

    sequence accepted_read;
        !frozen && !reg_wr_en && reg_rd_en;
    endsequence

    AST_SR_STORE: assert property (sr_write |=> regs_r.soft_reset == ($past(reg_wdata) & `SOFT_RESET_WMASK))
        else $error("soft reset write not stored");
    AST_CG_STORE: assert property (cg_write |=> regs_r.clock_gating == ($past(reg_wdata) & `CLOCK_GATING_WMASK))
        else $error("clock gating write not stored");
    AST_RO_ZERO: assert property ((regs_r.soft_reset & ~`SOFT_RESET_WMASK) == 16'h0000
        && (regs_r.clock_gating & ~`CLOCK_GATING_WMASK) == 16'h0000)
        else $error("read-only bit set");
    AST_BIAS_PATH: assert property (sr_write ##0 reg_wdata[`SR_BIAS_BIT] |=> ##1 bias_calibration_soft_reset)
        else $error("bias reset not reached in two clocks");
    AST_LOSS_PATH: assert property (sr_write |=> ##1 {signal_loss_monitor_c_soft_reset,
        signal_loss_monitor_b_soft_reset, signal_loss_monitor_a_soft_reset} == $past(reg_wdata[3:1], 2))
        else $error("loss monitor resets wrong");
    AST_RESERVED_QUIET: assert property (sr_write ##0 reg_wdata[8:0] == 9'h000 |=> ##1
        !bias_calibration_soft_reset && !fuse_memory_soft_reset && !digital_loop_soft_reset)
        else $error("reserved bit moved a reset");
    AST_FROZEN_STICKY: assert property (frozen |=> frozen && !reg_ack
        && $stable(regs_r.soft_reset) && $stable(regs_r.clock_gating))
        else $error("frozen port accepted access");
    AST_FREEZE_ENTRY: assert property (cg_write ##0 reg_wdata[`CG_GLOBAL_BIT] |=> bus_frozen ##1 global_digital_gate)
        else $error("global gate not taken");
    AST_READ_BACK: assert property (accepted_read ##0 reg_addr == `CLOCK_GATING_OFS
        |=> reg_ack && reg_rdata == $past(regs_r.clock_gating))
        else $error("read data wrong");
    AST_FUSE_GATE_PATH: assert property (cg_write ##0 !reg_wdata[`CG_FUSE_BIT] |=> ##1 !fuse_interface_gate)
        else $error("fuse gate not cleared");
    AST_ACK_ONCE: assert property (reg_ack |-> $past(!frozen && (reg_wr_en || reg_rd_en)))
        else $error("ack without accepted access");

    // ****************************************
    // Per-block paths, two clocks from write
    // ****************************************
    // Each output here carries only its own bit, so a swapped wire trips its label; the bias and loss monitor c resets have no label here
    AST_TIME_PATH: assert property (
        sr_write |=> ##1 time_converter_soft_reset == $past(reg_wdata[`SR_TIME_BIT], 2))
        else $error("time converter reset path wrong");

    AST_LOOP_PATH: assert property (
        sr_write |=> ##1 digital_loop_soft_reset == $past(reg_wdata[`SR_LOOP_BIT], 2))
        else $error("digital loop reset path wrong");

    AST_ACT_B_PATH: assert property (
        sr_write |=> ##1 activity_monitor_b_soft_reset == $past(reg_wdata[`SR_ACT_B_BIT], 2))
        else $error("activity monitor b reset path wrong");

    AST_ACT_A_PATH: assert property (
        sr_write |=> ##1 activity_monitor_a_soft_reset == $past(reg_wdata[`SR_ACT_A_BIT], 2))
        else $error("activity monitor a reset path wrong");

    AST_LOSS_B_PATH: assert property (
        sr_write |=> ##1 signal_loss_monitor_b_soft_reset == $past(reg_wdata[`SR_LOSS_B_BIT], 2))
        else $error("loss monitor b reset path wrong");

    AST_LOSS_A_PATH: assert property (
        sr_write |=> ##1 signal_loss_monitor_a_soft_reset == $past(reg_wdata[`SR_LOSS_A_BIT], 2))
        else $error("loss monitor a reset path wrong");

    AST_FUSE_RESET_PATH: assert property (
        sr_write |=> ##1 fuse_memory_soft_reset == $past(reg_wdata[`SR_FUSE_BIT], 2))
        else $error("fuse memory reset path wrong");

    AST_ACT_B_GATE_PATH: assert property (
        cg_write |=> ##1 activity_monitor_b_gate == $past(reg_wdata[`CG_ACT_B_BIT], 2))
        else $error("activity monitor b gate path wrong");

    AST_ACT_A_GATE_PATH: assert property (
        cg_write |=> ##1 activity_monitor_a_gate == $past(reg_wdata[`CG_ACT_A_BIT], 2))
        else $error("activity monitor a gate path wrong");

    AST_LOSS_C_GATE_PATH: assert property (
        cg_write |=> ##1 signal_loss_monitor_c_gate == $past(reg_wdata[`CG_LOSS_C_BIT], 2))
        else $error("loss monitor c gate path wrong");

    AST_LOSS_B_GATE_PATH: assert property (
        cg_write |=> ##1 signal_loss_monitor_b_gate == $past(reg_wdata[`CG_LOSS_B_BIT], 2))
        else $error("loss monitor b gate path wrong");

    AST_LOSS_A_GATE_PATH: assert property (
        cg_write |=> ##1 signal_loss_monitor_a_gate == $past(reg_wdata[`CG_LOSS_A_BIT], 2))
        else $error("loss monitor a gate path wrong");

    AST_FUSE_GATE_SET: assert property (
        cg_write |=> ##1 fuse_interface_gate == $past(reg_wdata[`CG_FUSE_BIT], 2))
        else $error("fuse gate path wrong");

    // ****************************************
    // Holding and acknowledging
    // ****************************************
    // A control only moves on an accepted write to its own word
    AST_SR_HOLD: assert property (
        !(!frozen && reg_wr_en && reg_addr == `SOFT_RESET_OFS)
        |=> $stable(regs_r.soft_reset))
        else $error("soft reset word moved without write");

    AST_CG_HOLD: assert property (
        !(!frozen && reg_wr_en && reg_addr == `CLOCK_GATING_OFS)
        |=> $stable(regs_r.clock_gating))
        else $error("clock gating word moved without write");

    AST_WRITE_ACK: assert property (
        !frozen && reg_wr_en |=> reg_ack)
        else $error("accepted write not acked");

    AST_RDATA_HOLD: assert property (
        !(!frozen && !reg_wr_en && reg_rd_en) |=> $stable(reg_rdata))
        else $error("read data moved without read");
endmodule

// File: verif/block_reset_and_clock_gating_tb_top.sv
// Purpose: self-checking bench for the soft reset and clock gating registers
// Assumes: decoded register strobes on mclk, ack registered at the taking edge and checked just after it
// Notes: controls lag the stored register by one clock, so checks wait one extra edge
`timescale 1ns/1ps
`include "blk_ctrl_defs.svh"
module block_reset_and_clock_gating_tb_top;
    import blk_ctrl_pkg::*;

    // ****************************************
    // Signals and design
    // ****************************************
    logic mclk;
    logic rst_b;
    logic reg_wr_en;
    logic reg_rd_en;
    reg_addr_t reg_addr;
    reg_word_t reg_wdata;
    reg_word_t reg_rdata;
    logic reg_ack;
    logic bus_frozen;
    logic bias_calibration_soft_reset;
    logic time_converter_soft_reset;
    logic digital_loop_soft_reset;
    logic activity_monitor_b_soft_reset;
    logic activity_monitor_a_soft_reset;
    logic signal_loss_monitor_c_soft_reset;
    logic signal_loss_monitor_b_soft_reset;
    logic signal_loss_monitor_a_soft_reset;
    logic fuse_memory_soft_reset;
    logic activity_monitor_b_gate;
    logic activity_monitor_a_gate;
    logic signal_loss_monitor_c_gate;
    logic signal_loss_monitor_b_gate;
    logic signal_loss_monitor_a_gate;
    logic fuse_interface_gate;
    logic global_digital_gate;
    logic [15:0] rst_vec;
    logic [15:0] gate_vec;
    int n_errors;
    int n_tests;

    // Outputs packed in register bit order
    assign rst_vec = {7'h00, bias_calibration_soft_reset, time_converter_soft_reset, digital_loop_soft_reset,
        activity_monitor_b_soft_reset, activity_monitor_a_soft_reset, signal_loss_monitor_c_soft_reset,
        signal_loss_monitor_b_soft_reset, signal_loss_monitor_a_soft_reset, fuse_memory_soft_reset};
    assign gate_vec = {10'h000, activity_monitor_b_gate, activity_monitor_a_gate, signal_loss_monitor_c_gate,
        signal_loss_monitor_b_gate, signal_loss_monitor_a_gate, fuse_interface_gate};

    block_reset_clock_ctrl dut (
        .mclk(mclk),
        .rst_b(rst_b),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_ack(reg_ack),
        .bus_frozen(bus_frozen),
        .bias_calibration_soft_reset(bias_calibration_soft_reset),
        .time_converter_soft_reset(time_converter_soft_reset),
        .digital_loop_soft_reset(digital_loop_soft_reset),
        .activity_monitor_b_soft_reset(activity_monitor_b_soft_reset),
        .activity_monitor_a_soft_reset(activity_monitor_a_soft_reset),
        .signal_loss_monitor_c_soft_reset(signal_loss_monitor_c_soft_reset),
        .signal_loss_monitor_b_soft_reset(signal_loss_monitor_b_soft_reset),
        .signal_loss_monitor_a_soft_reset(signal_loss_monitor_a_soft_reset),
        .fuse_memory_soft_reset(fuse_memory_soft_reset),
        .activity_monitor_b_gate(activity_monitor_b_gate),
        .activity_monitor_a_gate(activity_monitor_a_gate),
        .signal_loss_monitor_c_gate(signal_loss_monitor_c_gate),
        .signal_loss_monitor_b_gate(signal_loss_monitor_b_gate),
        .signal_loss_monitor_a_gate(signal_loss_monitor_a_gate),
        .fuse_interface_gate(fuse_interface_gate),
        .global_digital_gate(global_digital_gate)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access; strobes drop at the taking edge, so a gap cycle follows
    task automatic access(input logic wr, input reg_addr_t addr, input reg_word_t wdata, input logic exp_ack);
        @(posedge mclk);
        reg_wr_en <= wr;
        reg_rd_en <= ~wr;
        reg_addr <= addr;
        reg_wdata <= wdata;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        #1;
        check({15'h0000, reg_ack}, {15'h0000, exp_ack});
    endtask

    task automatic rd(input reg_addr_t addr, input reg_word_t exp);
        access(1'b0, addr, 16'h0000, 1'b1);
        check(reg_rdata, exp);
    endtask

    task automatic settle();
        @(posedge mclk);
        #1;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole run needs about 120 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        complete_run();
    end

    initial begin
        n_errors = 0;
        n_tests = 0;
        rst_b = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        check(rst_vec | gate_vec, 16'h0000);
        rd(`SOFT_RESET_OFS, 16'h0000);
        rd(`CLOCK_GATING_OFS, 16'h0000);
        for (int b = 0; b < 9; b++) begin
            access(1'b1, `SOFT_RESET_OFS, 16'h0001 << b, 1'b1);
            settle();
            check(rst_vec, 16'h0001 << b);
            check(gate_vec, 16'h0000);
        end
        repeat (20) @(posedge mclk);
        check(rst_vec, 16'h0100);
        for (int b = 0; b < 6; b++) begin
            access(1'b1, `CLOCK_GATING_OFS, 16'h0001 << b, 1'b1);
            settle();
            check(gate_vec, 16'h0001 << b);
            check({15'h0000, global_digital_gate}, 16'h0000);
        end
        // Reserved bits: read-only ones drop, writable ones stick without effect
        access(1'b1, `SOFT_RESET_OFS, 16'hFFFF, 1'b1);
        rd(`SOFT_RESET_OFS, 16'h09FF);
        check(rst_vec, 16'h01FF);
        access(1'b1, `SOFT_RESET_OFS, 16'h0800, 1'b1);
        rd(`SOFT_RESET_OFS, 16'h0800);
        check(rst_vec, 16'h0000);
        access(1'b1, `CLOCK_GATING_OFS, 16'hF7FF, 1'b1);
        rd(`CLOCK_GATING_OFS, 16'h017F);
        check({gate_vec[14:0], global_digital_gate}, 16'h007E);
        access(1'b1, `CLOCK_GATING_OFS, 16'h0140, 1'b1);
        rd(`CLOCK_GATING_OFS, 16'h0140);
        check(gate_vec, 16'h0000);
        // Unmapped index: acked, no effect, reads zero
        access(1'b1, 8'h05, 16'hFFFF, 1'b1);
        rd(8'h05, 16'h0000);
        rd(`SOFT_RESET_OFS, 16'h0800);
        // Back to back write then read
        @(posedge mclk);
        reg_wr_en <= 1'b1;
        reg_addr <= `CLOCK_GATING_OFS;
        reg_wdata <= 16'h0021;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b1;
        #1;
        check({15'h0000, reg_ack}, 16'h0001);
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        #1;
        check({15'h0000, reg_ack}, 16'h0001);
        check(reg_rdata, 16'h0021);
        // Global gate freezes the port until reset
        access(1'b1, `CLOCK_GATING_OFS, 16'h0821, 1'b1);
        settle();
        check({14'h0000, global_digital_gate, bus_frozen}, 16'h0003);
        check(gate_vec, 16'h0021);
        access(1'b1, `SOFT_RESET_OFS, 16'h01FF, 1'b0);
        access(1'b0, `CLOCK_GATING_OFS, 16'h0000, 1'b0);
        check(reg_rdata, 16'h0021);
        repeat (3) settle();
        check(rst_vec, 16'h0000);
        check({15'h0000, global_digital_gate}, 16'h0001);
        // Reset stands for the power cycle
        rst_b <= 1'b0;
        repeat (2) settle();
        check({gate_vec[14:0], global_digital_gate}, 16'h0000);
        rst_b <= 1'b1;
        rd(`CLOCK_GATING_OFS, 16'h0000);
        rd(`SOFT_RESET_OFS, 16'h0000);
        access(1'b1, `SOFT_RESET_OFS, 16'h0001, 1'b1);
        settle();
        check(rst_vec, 16'h0001);
        complete_run();
    end
endmodule
